// *** design/dtm_fall_det.sv ***
`timescale 1ns/1ps
module dtm_fall_det (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input dtm_pkg::dtm_pins_t pins, // Sampled pin levels
    output dtm_pkg::dtm_pins_t falls // One-cycle high-to-low pulses
);
    import dtm_pkg::*;
    dtm_fall_t s;
    dtm_fall_t next_s;
    logic [3:0] pinBits;

    assign pinBits = pins;

    // Previous level starts at the pins' idle high, so leaving reset shows no edge
    always_comb begin
        next_s.prev = pinBits;
        next_s.fall = 4'h0;
        for (int i = 0; i < 4; i++) begin
            next_s.fall[i] = s.prev[i] & ~pinBits[i];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s <= {4'hF, 4'h0};
        end else begin
            s <= next_s;
        end
    end

    assign falls = s.fall;
endmodule

// *** design/dtm_map.svh ***
`ifndef DTM_MAP_SVH
`define DTM_MAP_SVH
// Register indices; byte address is four times the index
`define DTM_IDX_TCS 8'h88
`define DTM_IDX_TMS 8'h89
`define DTM_IDX_C0LO 8'h8A
`define DTM_IDX_C1LO 8'h8B
`define DTM_IDX_C0HI 8'h8C
`define DTM_IDX_C1HI 8'h8D
`define DTM_IDX_DIV 8'h8E
`define DTM_IDX_IRQST 8'h90
`define DTM_IDX_IRQMSK 8'h91
// Control/status field positions
`define DTM_TF1 7
`define DTM_TR1 6
`define DTM_TF0 5
`define DTM_TR0 4
`define DTM_IE1 3
`define DTM_IT1 2
`define DTM_IE0 1
`define DTM_IT0 0
// Mode register field positions
`define DTM_PIN_QUALIFY_B 7
`define DTM_SRC1 6
`define DTM_MODE1_HI 5
`define DTM_MODE1_LO 4
`define DTM_PIN_QUALIFY_A 3
`define DTM_SRC0 2
`define DTM_MODE0_HI 1
`define DTM_MODE0_LO 0
// Divide-select field positions
`define DTM_DIVSEL_A 3
`define DTM_DIVSEL_B 4
// Reset values
`define DTM_RST_TCS 8'h00
`define DTM_RST_TMS 8'h00
`define DTM_RST_CNT 8'h00
// Slow tick divide ratio
`define DTM_TICK_DIV 12
`endif

// *** design/dtm_pkg.sv ***
package dtm_pkg;
    typedef enum logic [1:0] {
        DTM_MODE_13 = 2'b00,
        DTM_MODE_16 = 2'b01,
        DTM_MODE_RELOAD = 2'b10,
        DTM_MODE_SPLIT = 2'b11
    } dtm_mode_enc_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dtm_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dtm_apb_rsp_t;
    typedef struct packed {
        logic extIrqPinB;
        logic extIrqPinA;
        logic countPinB;
        logic countPinA;
    } dtm_pins_t;
    typedef struct packed {
        logic ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } dtm_cnt_t;
    typedef struct packed {
        logic [3:0] count;
        logic pulse;
    } dtm_pre_t;
    typedef struct packed {
        logic [3:0] prev;
        logic [3:0] fall;
    } dtm_fall_t;
    typedef struct packed {
        logic [7:0] tcs;
        logic [7:0] tms;
        logic [7:0] cnt0Lo;
        logic [7:0] cnt0Hi;
        logic [7:0] cnt1Lo;
        logic [7:0] cnt1Hi;
        logic [1:0] divSel;
        logic [1:0] irqStatus;
        logic [1:0] irqMask;
        logic [1:0] irqReq;
        logic irq;
        logic baudTick;
        dtm_apb_rsp_t rsp;
    } dtm_state_t;
endpackage

// *** design/dtm_prescale.sv ***
`timescale 1ns/1ps
`include "dtm_map.svh"
module dtm_prescale #(
    parameter int DIV = `DTM_TICK_DIV
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    output logic tick // One pulse every DIV clocks
);
    import dtm_pkg::*;
    dtm_pre_t s;
    dtm_pre_t next_s;

    // Free-running divider; shared by both timers so their slow ticks align
    always_comb begin
        next_s = s;
        if (s.count == 4'(DIV - 1)) begin
            next_s.count = 4'h0;
            next_s.pulse = 1'b1;
        end else begin
            next_s.count = s.count + 4'h1;
            next_s.pulse = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.pulse;
endmodule

// *** design/dtm_timer_top.sv ***
`timescale 1ns/1ps
`include "dtm_map.svh"
// Behaviour
// R1 - Auto-reload: low byte counts, high holds reload
// R2 - Low rollover sets flag, reloads from high
// R3 - Reload never alters the high byte
// R4 - Software preloads low byte before starting
// R5 - Set flag with enable raises timer request
// R6 - Split: timer 0 low uses own controls
// R7 - Split low byte: internal or external source
// R8 - Split high: internal, run B, flag B
// R9 - Timer 1 in mode 3 stops
// R10 - Split: timer 1 no external, no flag
// R11 - Timer 1 overflow still feeds baud tick
// R12 - Timer 1 auto-reload mirrors timer 0
// R13 - Count needs run and (no gate or pin)
// R14 - Counter function counts pin falling edges
// R15 - Timer ticks at clock/1 or clock/12
// R16 - Mode field: 13,16,reload,split/stopped
// R17 - Flag cleared by vector or software
module dtm_timer_top (
    input wire logic clk_sys, // System clock, 200 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input dtm_pkg::dtm_apb_req_t apbReq, // APB request signals
    output dtm_pkg::dtm_apb_rsp_t apbRsp, // APB answer signals
    input dtm_pkg::dtm_pins_t pins, // Count and external interrupt pins
    input wire logic [1:0] vectorAck, // CPU vectored to timer 0/1 interrupt
    output logic [1:0] irqReq, // Per-timer interrupt requests
    output logic irq, // Combined masked interrupt level
    output logic baudTick // Timer 1 overflow pulse for the serial port
);
    import dtm_pkg::*;

    // Whole block state is one packed struct, registered in one place
    dtm_state_t s;
    dtm_state_t next_s;
    dtm_pins_t falls;
    logic slowTick;

    // Shared slow tick, so both timers divide by twelve in step
    dtm_prescale #(
        .DIV(`DTM_TICK_DIV)
    ) uPrescale (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(slowTick)
    );

    // Registered falling-edge pulses for all four pins
    dtm_fall_det uFall (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pins(pins),
        .falls(falls)
    );

    // One step of a counter in the given mode
    // The carry out is the overflow event; flags and the baud pulse use it
    // Split mode only steps the low byte here, the high half counts apart
    function automatic dtm_cnt_t stepCnt(input logic [1:0] mode, input logic [7:0] lo,
                                         input logic [7:0] hi, input logic inc);
        dtm_cnt_t r;
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        // Default: hold both bytes, no overflow
        r.lo = lo;
        r.hi = hi;
        r.ovf = 1'b0;
        // All sums are formed, the mode picks one
        s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        s16 = {1'b0, hi, lo} + 17'h00001;
        s8 = {1'b0, lo} + 9'h001;
        // Nothing moves without an increment strobe
        if (inc) begin
            case (mode)
                DTM_MODE_13: begin
                    // Upper three low bits are left alone, software masks them
                    r.hi = s13[12:5]; // R16
                    r.lo = {lo[7:5], s13[4:0]};
                    r.ovf = s13[13];
                end
                DTM_MODE_16: begin
                    // Full 16-bit carry chain
                    r.hi = s16[15:8]; // R16
                    r.lo = s16[7:0];
                    r.ovf = s16[16];
                end
                DTM_MODE_RELOAD: begin
                    // Low byte counts, high byte is only the reload store
                    r.ovf = s8[8]; // R1
                    r.lo = s8[8] ? hi : s8[7:0]; // R2
                    r.hi = hi; // R3
                end
                default: begin
                    // Split mode low byte: a plain 8-bit wrap
                    r.lo = s8[7:0]; // R6
                    r.ovf = s8[8];
                end
            endcase
        end
        return r;
    endfunction

    // Decoded controls and per-timer count strobes
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic split0;
    logic stop1;
    logic tickA;
    logic tickB;
    logic enable0;
    logic enable1;
    logic inc0;
    logic inc1;
    logic incSplitHi;
    dtm_cnt_t step0;
    dtm_cnt_t step1;
    logic [8:0] splitHiSum;
    logic splitHiOvf;
    logic tf0Set;
    logic tf1Set;
    logic ovf1Raw;
    logic [1:0] runBit;
    logic [1:0] gateBit;
    logic [1:0] gatePin;
    logic [1:0] timerEn;
    logic [1:0] timerTick;

    // Run bits, gate bits and gate pins gathered per timer
    assign runBit = {s.tcs[`DTM_TR1], s.tcs[`DTM_TR0]};
    assign gateBit = {s.tms[`DTM_PIN_QUALIFY_B], s.tms[`DTM_PIN_QUALIFY_A]};
    assign gatePin = {pins.extIrqPinB, pins.extIrqPinA};

    // Same qualifier and tick choice for each timer, one copy each
    generate
        for (genvar i = 0; i < 2; i++) begin : gTimer
            // A set gate bit hands the decision to the pin; the run bit is always needed
            assign timerEn[i] = runBit[i] & (~gateBit[i] | gatePin[i]); // R13
            // Fast select skips the shared prescaler
            assign timerTick[i] = s.divSel[i] | slowTick; // R15
        end
    endgenerate

    // Mode decode and count enables
    // Timer 1 in mode 3 is held still; that is its off switch
    always_comb begin
        mode0 = s.tms[`DTM_MODE0_HI:`DTM_MODE0_LO];
        mode1 = s.tms[`DTM_MODE1_HI:`DTM_MODE1_LO];
        split0 = (mode0 == DTM_MODE_SPLIT); // R16
        stop1 = (mode1 == DTM_MODE_SPLIT); // R9
        tickA = timerTick[0]; // R15
        tickB = timerTick[1]; // R15
        enable0 = timerEn[0]; // R13
        enable1 = timerEn[1]; // R13
        // Timer 0 (or its split low half) keeps its own source select
        inc0 = enable0 & (s.tms[`DTM_SRC0] ? falls.countPinA : tickA); // R7 R14
        // External source is refused for timer 1 while timer 0 is split
        inc1 = enable1 & ~stop1 &
               ((s.tms[`DTM_SRC1] & ~split0) ? falls.countPinB : tickB); // R9 R10 R12 R14
        // Split high half: run bit B only, no gate, internal tick only
        incSplitHi = split0 & s.tcs[`DTM_TR1] & tickA; // R8
    end

    // Counter arithmetic for both timers
    // Timer 1's own carry is kept apart from flag B, which split mode lends out
    always_comb begin
        step0 = stepCnt(mode0, s.cnt0Lo, s.cnt0Hi, inc0); // R6
        step1 = stepCnt(mode1, s.cnt1Lo, s.cnt1Hi, inc1); // R12
        splitHiSum = {1'b0, s.cnt0Hi} + 9'h001;
        splitHiOvf = incSplitHi & splitHiSum[8]; // R8
        ovf1Raw = step1.ovf;
        tf0Set = step0.ovf; // R2 R6
        // Flag B belongs to the split high half while timer 0 is split
        tf1Set = split0 ? splitHiOvf : ovf1Raw; // R8 R10
    end

    // Address decode results
    logic [7:0] idx;
    logic hit;
    logic [31:0] readVal;
    logic setup;
    logic commit;

    // Address decode and read mux; unmapped words answer with an error
    // Upper address bits must be zero, so aliases never reach a register
    // The read value is taken at setup, so a count may move during access
    always_comb begin
        // Word index from the byte address
        idx = apbReq.paddr[9:2];
        hit = 1'b1;
        readVal = 32'h0000_0000;
        if (apbReq.paddr[11:10] != 2'h0) begin
            hit = 1'b0;
        end else if (idx == `DTM_IDX_TCS) begin
            readVal = {24'h00_0000, s.tcs};
        end else if (idx == `DTM_IDX_TMS) begin
            readVal = {24'h00_0000, s.tms};
        end else if (idx == `DTM_IDX_C0LO) begin
            readVal = {24'h00_0000, s.cnt0Lo};
        end else if (idx == `DTM_IDX_C1LO) begin
            readVal = {24'h00_0000, s.cnt1Lo};
        end else if (idx == `DTM_IDX_C0HI) begin
            readVal = {24'h00_0000, s.cnt0Hi};
        end else if (idx == `DTM_IDX_C1HI) begin
            readVal = {24'h00_0000, s.cnt1Hi};
        end else if (idx == `DTM_IDX_DIV) begin
            readVal = {27'h000_0000, s.divSel[1], s.divSel[0], 3'h0};
        end else if (idx == `DTM_IDX_IRQST) begin
            readVal = {30'h0000_0000, s.irqStatus};
        end else if (idx == `DTM_IDX_IRQMSK) begin
            readVal = {30'h0000_0000, s.irqMask};
        end else begin
            hit = 1'b0;
        end
        // Setup is the only cycle that loads the answer
        setup = apbReq.psel & ~apbReq.penable;
        commit = apbReq.psel & apbReq.penable & s.rsp.pready & apbReq.pwrite & hit;
    end

    // Write byte and the control word being built
    logic [7:0] wb;
    logic [7:0] tcsNext;

    // Next state: counting first, then software writes, then hardware sets
    // Later assignments win, so hardware events beat any clear
    always_comb begin
        next_s = s;
        wb = apbReq.pwdata[7:0];
        tcsNext = s.tcs;

        // Answer one cycle after setup, so every access has a single wait-free phase
        if (setup) begin
            next_s.rsp.pready = 1'b1;
            next_s.rsp.prdata = readVal;
            next_s.rsp.pslverr = ~hit;
        end else begin
            next_s.rsp.pready = 1'b0;
            next_s.rsp.pslverr = 1'b0;
        end

        // Counting
        next_s.cnt0Lo = step0.lo; // R1
        // In split mode the high byte is the second counter, not a reload store
        next_s.cnt0Hi = split0 ? (incSplitHi ? splitHiSum[7:0] : s.cnt0Hi) : step0.hi; // R3 R8
        // Timer 1 always steps through the shared function
        next_s.cnt1Lo = step1.lo; // R12
        next_s.cnt1Hi = step1.hi;

        // A software write to a count byte wins over that cycle's count
        // Unmapped words never commit, so a refused write leaves state alone
        if (commit) begin
            if (idx == `DTM_IDX_TCS) begin
                tcsNext = wb;
            end else if (idx == `DTM_IDX_TMS) begin
                next_s.tms = wb;
            end else if (idx == `DTM_IDX_C0LO) begin
                next_s.cnt0Lo = wb;
            end else if (idx == `DTM_IDX_C1LO) begin
                next_s.cnt1Lo = wb;
            end else if (idx == `DTM_IDX_C0HI) begin
                next_s.cnt0Hi = wb;
            end else if (idx == `DTM_IDX_C1HI) begin
                next_s.cnt1Hi = wb;
            end else if (idx == `DTM_IDX_DIV) begin
                next_s.divSel = {wb[`DTM_DIVSEL_B], wb[`DTM_DIVSEL_A]};
            end else if (idx == `DTM_IDX_IRQST) begin
                next_s.irqStatus = s.irqStatus & ~wb[1:0];
            end else if (idx == `DTM_IDX_IRQMSK) begin
                next_s.irqMask = wb[1:0];
            end
        end

        // Vectoring clears the overflow flags
        // An overflow in the same cycle is set again below
        if (vectorAck[0]) begin
            tcsNext[`DTM_TF0] = 1'b0; // R17
        end
        if (vectorAck[1]) begin
            tcsNext[`DTM_TF1] = 1'b0; // R17
        end

        // Level-triggered flags follow the pin; edge ones are sticky
        // An edge-mode flag needs a software write to clear
        if (!s.tcs[`DTM_IT0] && pins.extIrqPinA) begin
            tcsNext[`DTM_IE0] = 1'b0;
        end
        if (!s.tcs[`DTM_IT1] && pins.extIrqPinB) begin
            tcsNext[`DTM_IE1] = 1'b0;
        end

        // Hardware sets come last so a same-cycle clear never loses an event
        if (tf0Set) begin
            tcsNext[`DTM_TF0] = 1'b1; // R2
        end
        if (tf1Set) begin
            tcsNext[`DTM_TF1] = 1'b1; // R8
        end
        // Edge mode uses the registered fall pulse, level mode the raw pin
        if (s.tcs[`DTM_IT0] ? falls.extIrqPinA : ~pins.extIrqPinA) begin
            tcsNext[`DTM_IE0] = 1'b1;
        end
        if (s.tcs[`DTM_IT1] ? falls.extIrqPinB : ~pins.extIrqPinB) begin
            tcsNext[`DTM_IE1] = 1'b1;
        end
        // Control word is final only after every set and clear
        next_s.tcs = tcsNext;

        // Sticky event bits, write one to clear, set wins
        next_s.irqStatus = next_s.irqStatus | {tf1Set, tf0Set};

        // Requests and combined level
        // A mask write takes effect one cycle after it lands
        next_s.irqReq = {tcsNext[`DTM_TF1], tcsNext[`DTM_TF0]} & s.irqMask; // R5
        next_s.irq = |(next_s.irqStatus & s.irqMask);

        // Baud tick ignores split mode and flag suppression
        // The serial port keeps its tick even when flag B is lent out
        next_s.baudTick = ovf1Raw; // R11
    end

    // State register
    // Synchronous reset; the helpers clear on the same edge, so one edge is enough
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // Clear everything, then load the register reset values
            s <= '0;
            s.tcs <= `DTM_RST_TCS;
            s.tms <= `DTM_RST_TMS;
            s.cnt0Lo <= `DTM_RST_CNT;
            s.cnt0Hi <= `DTM_RST_CNT;
            s.cnt1Lo <= `DTM_RST_CNT;
            s.cnt1Hi <= `DTM_RST_CNT;
        end else begin
            s <= next_s;
        end
    end

    // All outputs straight from the state register
    // Nothing combinational reaches a port, so pin timing stays clean
    assign apbRsp = s.rsp;
    assign irqReq = s.irqReq;
    assign irq = s.irq;
    assign baudTick = s.baudTick;
endmodule

// *** dv/dtm_pin_model.sv ***
`timescale 1ns/1ps
module dtm_pin_model (
    input wire logic clk_sys, // Clock
    output dtm_pkg::dtm_pins_t pins // Pin levels
);
    import dtm_pkg::*;
    // Pins idle high, no edge at start
    initial pins = '1;
    // Low held two clocks, high three or more, so the sampler cannot miss it
    task automatic fall(input int b, input int n);
        repeat (n) begin
            @(posedge clk_sys) pins[b] <= 1'b0;
            repeat (2) @(posedge clk_sys);
            pins[b] <= 1'b1;
            repeat (2) @(posedge clk_sys);
        end
    endtask
    // Gate level on an external interrupt pin
    task automatic pin(input int b, input logic v);
        @(posedge clk_sys) pins[b] <= v;
    endtask
endmodule

// *** dv/dtm_timer_sva.sv ***
`timescale 1ns/1ps
module dtm_timer_sva (
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset
    input dtm_pkg::dtm_apb_req_t apbReq, // APB in
    input dtm_pkg::dtm_apb_rsp_t apbRsp, // APB out
    input dtm_pkg::dtm_pins_t pins, // Pins
    input wire logic [1:0] vectorAck, // Acks
    input wire logic [1:0] irqReq, // Requests
    input wire logic irq, // Interrupt
    input wire logic baudTick // Baud pulse
);
    import dtm_pkg::*;
    logic setup;
    logic mapped;
    logic [7:0] idx;
    // Own decode, so a shifted map is caught at once
    assign idx = apbReq.paddr[9:2];
    assign setup = apbReq.psel && !apbReq.penable;
    assign mapped = apbReq.paddr[11:10] == 2'b00 && (idx inside {[8'h88:8'h8E], 8'h90, 8'h91});
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_ready_after_setup: assert property (setup |=> apbRsp.pready)
        else $error("no pready after setup");
    a_ready_no_setup: assert property (!setup |=> !apbRsp.pready)
        else $error("pready without setup");
    a_err_unmapped: assert property (setup && !mapped |=> apbRsp.pslverr && apbRsp.prdata == 32'h0)
        else $error("unmapped word not refused");
    a_ok_mapped: assert property (setup && mapped |=> !apbRsp.pslverr)
        else $error("mapped word refused");
    a_err_with_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
        else $error("pslverr without pready");
    a_data_held: assert property (!apbReq.psel |=> $stable(apbRsp.prdata))
        else $error("prdata moved while idle");
    a_data_narrow: assert property (apbRsp.pready |-> apbRsp.prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    // A request that rises without a write must come from an overflow
    a_irq_on_flag: assert property (((irqReq & ~$past(irqReq)) != 2'b00) && !$past(apbReq.penable) |-> irq)
        else $error("request without interrupt");
    a_quiet_after_rst: assert property ($rose(rst_n) |-> !irq && irqReq == 2'b00 && !baudTick && !apbRsp.pready)
        else $error("outputs busy after reset");
    cover property (apbRsp.pslverr);
    cover property (baudTick);
    cover property ($rose(irq));
endmodule

bind dtm_timer_top dtm_timer_sva chk (.clk_sys(clk_sys), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
    .pins(pins), .vectorAck(vectorAck), .irqReq(irqReq), .irq(irq), .baudTick(baudTick));

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`include "dtm_map.svh"
module tb_top;
    import dtm_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    dtm_apb_req_t req = '0;
    dtm_apb_rsp_t rsp;
    dtm_pins_t pins;
    logic [1:0] vectorAck = 2'b00;
    logic [1:0] irqReq;
    logic irq;
    logic baudTick;
    logic [31:0] rdat;
    logic rerr;
    int miscompares = 0;
    int n_checks = 0;
    int nBaud = 0;
    int mLo[2];
    int mHi[2];
    int mTf[2];
    int mOvf[2];

    dtm_timer_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .apbReq(req), .apbRsp(rsp), .pins(pins),
        .vectorAck(vectorAck), .irqReq(irqReq), .irq(irq), .baudTick(baudTick));
    dtm_pin_model pm (.clk_sys(clk_sys), .pins(pins));

    always #2.5 clk_sys = ~clk_sys;
    // Baud pulses last one cycle, so count them as they come
    always @(posedge clk_sys) if (baudTick === 1'b1) nBaud++;

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s exp %0h got %0h", nm, e, g);
        end
    endtask

    // One APB transfer; waits on pready, no fixed latency assumed
    task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] wd);
        int t;
        t = 0;
        @(posedge clk_sys);
        req <= {1'b1, 1'b0, w, 2'b00, ix, 2'b00, 24'h0, wd};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do @(posedge clk_sys); while (rsp.pready !== 1'b1 && ++t < 50);
        rdat = rsp.prdata;
        rerr = rsp.pslverr;
        if (t >= 50) chk("pready", 1, 0);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        apb(1'b1, ix, d);
    endtask

    task automatic rdc(input string nm, input logic [7:0] ix, input logic [7:0] e);
        apb(1'b0, ix, 8'h00);
        chk(nm, {24'h0, e}, rdat);
    endtask

    // Reference counter: low byte counts, rollover reloads from high
    task automatic mfall(input int t, input int n);
        repeat (n) begin
            if (mLo[t] == 255) begin
                mLo[t] = mHi[t];
                mTf[t] = 1;
                mOvf[t]++;
            end else begin
                mLo[t]++;
            end
        end
    endtask

    initial begin
        int n;
        int b;
        void'($urandom(32'hAD09));
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Reset values, mode register access, unmapped word
        rdc("ctrl", `DTM_IDX_TCS, 8'h00);
        rdc("mode", `DTM_IDX_TMS, 8'h00);
        wr(`DTM_IDX_TMS, 8'h5A);
        rdc("mode rw", `DTM_IDX_TMS, 8'h5A);
        apb(1'b0, 8'h8F, 8'h00);
        chk("unmapped", 1, {31'h0, rerr});
        $display("test regs done");
        // Auto-reload on each timer, pin-counted, gate first held closed
        wr(`DTM_IDX_IRQMSK, 8'h03);
        for (int t = 0; t < 2; t++) begin
            mHi[t] = 8'hF8 + $urandom % 8;
            mLo[t] = 8'hFD;
            mTf[t] = 0;
            mOvf[t] = 0;
            wr(`DTM_IDX_TMS, t ? 8'hE0 : 8'h0E);
            wr(8'(`DTM_IDX_C0LO + t), 8'(mLo[t]));
            wr(8'(`DTM_IDX_C0HI + t), 8'(mHi[t]));
            wr(`DTM_IDX_TCS, t ? 8'h40 : 8'h10);
            pm.pin(2 + t, 1'b0);
            pm.fall(t, 2);
            rdc("gated", 8'(`DTM_IDX_C0LO + t), 8'(mLo[t]));
            pm.pin(2 + t, 1'b1);
            b = nBaud;
            n = 4 + $urandom % 12;
            pm.fall(t, n);
            mfall(t, n);
            rdc("count", 8'(`DTM_IDX_C0LO + t), 8'(mLo[t]));
            rdc("reload", 8'(`DTM_IDX_C0HI + t), 8'(mHi[t]));
            rdc("flag", `DTM_IDX_TCS, 8'(t ? 8'h40 | mTf[t] << 7 : 8'h10 | mTf[t] << 5));
            chk("req", mTf[t] << t, {30'h0, irqReq});
            chk("baud", t ? mOvf[1] : 0, nBaud - b);
            chk("irq", 1, {31'h0, irq});
            @(posedge clk_sys) vectorAck[t] <= 1'b1;
            @(posedge clk_sys) vectorAck <= 2'b00;
            rdc("ack", `DTM_IDX_TCS, t ? 8'h40 : 8'h10);
            wr(`DTM_IDX_IRQST, 8'(1 << t));
            @(posedge clk_sys);
            chk("irq clr", 0, {31'h0, irq});
            wr(`DTM_IDX_TCS, 8'h00);
            $display("test reload %0d done", t);
        end
        // Split: low byte on pin A, high byte on fast tick under run B
        wr(`DTM_IDX_TMS, 8'h37);
        wr(`DTM_IDX_DIV, 8'h08);
        wr(`DTM_IDX_C0LO, 8'h10);
        wr(`DTM_IDX_C0HI, 8'hF0);
        wr(`DTM_IDX_C1LO, 8'h20);
        wr(`DTM_IDX_TCS, 8'h50);
        pm.fall(0, 3);
        pm.fall(1, 3);
        rdc("split lo", `DTM_IDX_C0LO, 8'h13);
        rdc("t1 stop", `DTM_IDX_C1LO, 8'h20);
        rdc("split flag", `DTM_IDX_TCS, 8'hD0);
        chk("split req", 2, {30'h0, irqReq});
        $display("test split done");
        // Split with timer 1 in reload on the fast tick: pin B ignored, flag B untouched
        wr(`DTM_IDX_DIV, 8'h10);
        wr(`DTM_IDX_C0HI, 8'h00);
        wr(`DTM_IDX_TCS, 8'h00);
        wr(`DTM_IDX_TMS, 8'h67);
        wr(`DTM_IDX_C1LO, 8'hF0);
        wr(`DTM_IDX_C1HI, 8'hF0);
        b = nBaud;
        wr(`DTM_IDX_TCS, 8'h40);
        pm.fall(1, 4);
        rdc("t1 no flag", `DTM_IDX_TCS, 8'h40);
        chk("t1 no req", 0, {30'h0, irqReq});
        chk("split baud", 1, 32'(nBaud > b));
        $display("test split timer1 done");
        summarize();
    end

    // Run needs a few hundred cycles; far beyond that is a hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        $display("[FAIL] watchdog exp done got hang");
        miscompares++;
        summarize();
    end
endmodule
